// ---- common/irq_ctrl_cfg.svh ----
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

// register offsets on the plain register port
`define OFS_CONTROL 3'h0
`define OFS_PFLAG_A 3'h1
`define OFS_PFLAG_B 3'h2
`define OFS_PEN_A 3'h3
`define OFS_PEN_B 3'h4
`define OFS_OPTION 3'h5
`define OFS_STATUS 3'h6

// irq_control_reg field positions
`define CTRL_GLOBAL_EN_BIT 7
`define CTRL_GROUP_EN_BIT 6
`define CTRL_TIMER_EN_BIT 5
`define CTRL_EXTIE_BIT 4
`define CTRL_PCIE_BIT 3
`define CTRL_TIMER_FLAG_BIT 2
`define CTRL_EXTIF_BIT 1
`define CTRL_PCIF_BIT 0

// option register and status register field positions
`define OPT_EDGE_BIT 6
`define STAT_PENDING_BIT 0
`define STAT_ENTRY_BIT 1

// reset values
`define CTRL_RESET 8'h00
`define PFLAG_RESET 8'h00
`define PEN_RESET 8'h00
`define OPTION_RESET 8'h40

// sizes, vector and entry timing
`define PERIPH_A_W 8
`define PERIPH_B_W 3
`define PORT_CHANGE_W 4
`define VECTOR_ADDR 13'h0004
`define ENTRY_CYCLES 2

`endif

// ---- common/irq_ctrl_pkg.sv ----
`default_nettype none

package irq_ctrl_pkg;

  typedef enum logic [1:0] {
    ENTRY_IDLE,
    ENTRY_FLUSH,
    ENTRY_PUSH
  } entry_state_e;

  typedef logic [12:0] code_addr_t;
  typedef logic [7:0] reg_byte_t;

endpackage

`default_nettype wire

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the output follows once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_level = level_o;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      level_o <= INIT;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

endmodule

`default_nettype wire

// ---- hw/interrupt_control_logic.sv ----
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"

module interrupt_control_logic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic external_irq_pin_i,
  input wire logic [`PORT_CHANGE_W-1:0] port_change_pins_i,
  input wire logic timer_zero_ovf_i,
  input wire logic [`PERIPH_A_W-1:0] periph_event_a_i,
  input wire logic [`PERIPH_B_W-1:0] periph_event_b_i,
  input wire logic instr_cycle_end_i,
  input wire logic return_from_irq_instr_i,
  input wire logic [12:0] return_addr_i,
  output logic irq_entry_o,
  output logic stack_push_o,
  output logic [12:0] stack_push_data_o,
  output logic program_counter_load_o,
  output logic [12:0] program_counter_o,
  output logic global_irq_enable_o,
  output logic irq_pending_o
);

  function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
    hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and event detection

  logic ext_level;
  logic [`PORT_CHANGE_W-1:0] port_level;
  logic ext_prev;
  logic [`PORT_CHANGE_W-1:0] port_prev;
  logic ext_event;
  logic port_event;
  logic [7:0] option_reg;

  pin_sync #(
    .WIDTH(1 + `PORT_CHANGE_W)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({external_irq_pin_i, port_change_pins_i}),
    .level_o({ext_level, port_level})
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_prev <= 1'b0;
      port_prev <= '0;
    end else begin
      ext_prev <= ext_level;
      port_prev <= port_level;
    end
  end

  always_comb begin
    if (option_reg[`OPT_EDGE_BIT]) begin
      ext_event = ext_level & ~ext_prev;
    end else begin
      ext_event = ~ext_level & ext_prev;
    end
    port_event = |(port_level ^ port_prev);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags and global enable

  logic [7:0] ctrl_reg;
  logic [`PERIPH_A_W-1:0] pflag_a;
  logic [`PERIPH_B_W-1:0] pflag_b;
  logic [`PERIPH_A_W-1:0] pen_a;
  logic [`PERIPH_B_W-1:0] pen_b;
  logic [7:0] next_ctrl;
  logic [`PERIPH_A_W-1:0] next_pflag_a;
  logic [`PERIPH_B_W-1:0] next_pflag_b;
  logic [`PERIPH_A_W-1:0] next_pen_a;
  logic [`PERIPH_B_W-1:0] next_pen_b;
  logic [7:0] next_option;
  logic [7:0] next_rdata;
  logic [7:0] core_set;
  logic core_pairs;
  logic periph_pairs;
  logic pending;
  logic accept;
  irq_ctrl_pkg::entry_state_e state;
  irq_ctrl_pkg::entry_state_e next_state;

  always_comb begin
    core_set = 8'h00;
    core_set[`CTRL_TIMER_FLAG_BIT] = timer_zero_ovf_i;
    core_set[`CTRL_EXTIF_BIT] = ext_event;
    core_set[`CTRL_PCIF_BIT] = port_event;
  end

  // pending request from the flag-enable pairs
  always_comb begin
    core_pairs = (ctrl_reg[`CTRL_TIMER_FLAG_BIT] & ctrl_reg[`CTRL_TIMER_EN_BIT])
      | (ctrl_reg[`CTRL_EXTIF_BIT] & ctrl_reg[`CTRL_EXTIE_BIT])
      | (ctrl_reg[`CTRL_PCIF_BIT] & ctrl_reg[`CTRL_PCIE_BIT]);
    periph_pairs = ctrl_reg[`CTRL_GROUP_EN_BIT]
      & (|(pflag_a & pen_a) | |(pflag_b & pen_b));
    pending = ctrl_reg[`CTRL_GLOBAL_EN_BIT] & (core_pairs | periph_pairs);
    accept = pending & instr_cycle_end_i & (state == irq_ctrl_pkg::ENTRY_IDLE);
  end

  // flags: a hardware set always wins over a software write
  always_comb begin
    next_ctrl = ctrl_reg;
    next_pflag_a = pflag_a;
    next_pflag_b = pflag_b;
    next_pen_a = pen_a;
    next_pen_b = pen_b;
    next_option = option_reg;
    if (reg_wr_i && hit(reg_addr_i, `OFS_CONTROL)) begin
      next_ctrl = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, `OFS_PFLAG_A)) begin
      next_pflag_a = reg_wdata_i[`PERIPH_A_W-1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, `OFS_PFLAG_B)) begin
      next_pflag_b = reg_wdata_i[`PERIPH_B_W-1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, `OFS_PEN_A)) begin
      next_pen_a = reg_wdata_i[`PERIPH_A_W-1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, `OFS_PEN_B)) begin
      next_pen_b = reg_wdata_i[`PERIPH_B_W-1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, `OFS_OPTION)) begin
      next_option = reg_wdata_i;
    end
    next_ctrl = next_ctrl | core_set;
    next_pflag_a = next_pflag_a | periph_event_a_i;
    next_pflag_b = next_pflag_b | periph_event_b_i;
    if (return_from_irq_instr_i) begin
      next_ctrl[`CTRL_GLOBAL_EN_BIT] = 1'b1;
    end
    if (accept) begin
      next_ctrl[`CTRL_GLOBAL_EN_BIT] = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, `OFS_CONTROL)) begin
        next_rdata = ctrl_reg;
      end else if (hit(reg_addr_i, `OFS_PFLAG_A)) begin
        next_rdata = pflag_a;
      end else if (hit(reg_addr_i, `OFS_PFLAG_B)) begin
        next_rdata = {5'h00, pflag_b};
      end else if (hit(reg_addr_i, `OFS_PEN_A)) begin
        next_rdata = pen_a;
      end else if (hit(reg_addr_i, `OFS_PEN_B)) begin
        next_rdata = {5'h00, pen_b};
      end else if (hit(reg_addr_i, `OFS_OPTION)) begin
        next_rdata = option_reg;
      end else if (hit(reg_addr_i, `OFS_STATUS)) begin
        next_rdata[`STAT_PENDING_BIT] = pending;
        next_rdata[`STAT_ENTRY_BIT] = (state != irq_ctrl_pkg::ENTRY_IDLE);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RESET;
      pflag_a <= `PFLAG_RESET;
      pflag_b <= '0;
      pen_a <= `PEN_RESET;
      pen_b <= '0;
      option_reg <= `OPTION_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      ctrl_reg <= next_ctrl;
      pflag_a <= next_pflag_a;
      pflag_b <= next_pflag_b;
      pen_a <= next_pen_a;
      pen_b <= next_pen_b;
      option_reg <= next_option;
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry sequence, stepped only at instruction-cycle boundaries

  logic next_entry;
  logic next_push;
  logic [12:0] next_push_data;
  logic next_pc_load;
  logic [12:0] next_pc;

  // boundaries are counted, not instruction completions, so latency is fixed
  always_comb begin
    next_state = state;
    next_push = 1'b0;
    next_pc_load = 1'b0;
    next_push_data = stack_push_data_o;
    next_pc = program_counter_o;
    unique case (state)
      irq_ctrl_pkg::ENTRY_IDLE: begin
        if (accept) begin
          next_state = irq_ctrl_pkg::ENTRY_FLUSH;
        end
      end
      irq_ctrl_pkg::ENTRY_FLUSH: begin
        if (instr_cycle_end_i) begin
          next_state = irq_ctrl_pkg::ENTRY_PUSH;
          next_push = 1'b1;
          next_push_data = return_addr_i;
        end
      end
      irq_ctrl_pkg::ENTRY_PUSH: begin
        if (instr_cycle_end_i) begin
          next_state = irq_ctrl_pkg::ENTRY_IDLE;
          next_pc_load = 1'b1;
          next_pc = `VECTOR_ADDR;
        end
      end
    endcase
    next_entry = (next_state != irq_ctrl_pkg::ENTRY_IDLE);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= irq_ctrl_pkg::ENTRY_IDLE;
      irq_entry_o <= 1'b0;
      stack_push_o <= 1'b0;
      stack_push_data_o <= 13'h0000;
      program_counter_load_o <= 1'b0;
      program_counter_o <= 13'h0000;
      global_irq_enable_o <= 1'b0;
      irq_pending_o <= 1'b0;
    end else begin
      state <= next_state;
      irq_entry_o <= next_entry;
      stack_push_o <= next_push;
      stack_push_data_o <= next_push_data;
      program_counter_load_o <= next_pc_load;
      program_counter_o <= next_pc;
      global_irq_enable_o <= next_ctrl[`CTRL_GLOBAL_EN_BIT];
      irq_pending_o <= pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [1:0] bounds_seen;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bounds_seen <= 2'h0;
    end else if (accept) begin
      bounds_seen <= 2'h0;
    end else if (instr_cycle_end_i && state != irq_ctrl_pkg::ENTRY_IDLE) begin
      bounds_seen <= bounds_seen + 2'h1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_timer_flag_set: assert property (
    timer_zero_ovf_i |=> ctrl_reg[`CTRL_TIMER_FLAG_BIT])
    else $error("timer-zero flag not set by its event");
  chk_periph_flag_set: assert property (
    periph_event_a_i[0] |=> pflag_a[0])
    else $error("peripheral flag not set by its event");
  chk_global_blocks: assert property (
    !ctrl_reg[`CTRL_GLOBAL_EN_BIT] |=> !irq_pending_o)
    else $error("request pending while global enable is clear");
  chk_accept_clears: assert property (
    accept |=> !global_irq_enable_o && irq_entry_o)
    else $error("entry did not clear global enable");
  chk_return_sets: assert property (
    (return_from_irq_instr_i && !accept) |=> global_irq_enable_o)
    else $error("return did not set global enable");
  chk_vector_addr: assert property (
    program_counter_load_o |-> program_counter_o == `VECTOR_ADDR && $past(state)
      == irq_ctrl_pkg::ENTRY_PUSH)
    else $error("vector load wrong");
  chk_entry_len: assert property (
    program_counter_load_o |-> bounds_seen == 2'(`ENTRY_CYCLES))
    else $error("entry length wrong");
  chk_push_before: assert property (
    stack_push_o |-> stack_push_data_o == $past(return_addr_i) && !global_irq_enable_o)
    else $error("push data or enable wrong");
  chk_masked_source: assert property (
    (!ctrl_reg[`CTRL_GROUP_EN_BIT] && !ctrl_reg[`CTRL_TIMER_EN_BIT]
      && !ctrl_reg[`CTRL_EXTIE_BIT]
      && !ctrl_reg[`CTRL_PCIE_BIT]) |=> !irq_pending_o)
    else $error("masked sources raised a request");
  chk_pending_vector: assert property (
    (pending && instr_cycle_end_i && state == irq_ctrl_pkg::ENTRY_IDLE) |=> irq_entry_o)
    else $error("pending request not taken");

  cov_entry: cover property (accept ##[1:20] program_counter_load_o);
  cov_ext_pin: cover property (ext_event ##[1:60] program_counter_load_o);
  cov_return: cover property (program_counter_load_o ##[1:40] return_from_irq_instr_i);
  cov_periph: cover property (periph_pairs && accept);

endmodule

`default_nettype wire

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// core stand-in: instruction-cycle boundaries, return address, return-from-irq issue
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic ret_req_i,
  input wire logic program_counter_load_i,
  input wire logic [12:0] program_counter_i,
  output logic instr_cycle_end_o,
  output logic return_from_irq_instr_o,
  output logic [12:0] return_addr_o,
  output logic [12:0] last_addr_o
);
  logic [3:0] cnt;
  logic pend;
  logic bnd;
  // slow mode stretches each instruction cycle from 8 to 12 clocks
  assign bnd = (cnt == (slow_i ? 4'hb : 4'h7));
  assign return_addr_o = last_addr_o + 13'h0001;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      pend <= 1'b0;
      instr_cycle_end_o <= 1'b0;
      return_from_irq_instr_o <= 1'b0;
      last_addr_o <= 13'h0100;
    end else begin
      cnt <= bnd ? 4'h0 : cnt + 4'h1;
      instr_cycle_end_o <= bnd;
      // the instruction is issued only on a boundary
      return_from_irq_instr_o <= bnd & pend;
      if (bnd) begin
        pend <= 1'b0;
      end
      if (ret_req_i) begin
        pend <= 1'b1;
      end
      if (instr_cycle_end_o) begin
        last_addr_o <= return_addr_o;
      end
      if (program_counter_load_i) begin
        last_addr_o <= program_counter_i - 13'h0001;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/test_interrupt_control_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"

module test_interrupt_control_logic;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic pin = 1'b0;
  logic [3:0] port_pins = 4'h0;
  logic timer_ovf = 1'b0;
  logic [7:0] ev_a = 8'h00;
  logic [2:0] ev_b = 3'h0;
  logic slow = 1'b0;
  logic ret_req = 1'b0;
  logic bnd, ret, entry, push, load, glob_en, pend;
  logic [12:0] ret_addr, push_data, pc, last_addr;
  int miscompares = 0;
  int checks_done = 0;
  int bnd_cnt = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (bnd === 1'b1) bnd_cnt <= bnd_cnt + 1;

  interrupt_control_logic i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .external_irq_pin_i(pin), .port_change_pins_i(port_pins), .timer_zero_ovf_i(timer_ovf),
    .periph_event_a_i(ev_a), .periph_event_b_i(ev_b), .instr_cycle_end_i(bnd),
    .return_from_irq_instr_i(ret), .return_addr_i(ret_addr), .irq_entry_o(entry),
    .stack_push_o(push), .stack_push_data_o(push_data), .program_counter_load_o(load),
    .program_counter_o(pc), .global_irq_enable_o(glob_en), .irq_pending_o(pend));

  core_model i_core (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ret_req_i(ret_req),
    .program_counter_load_i(load), .program_counter_i(pc), .instr_cycle_end_o(bnd),
    .return_from_irq_instr_o(ret), .return_addr_o(ret_addr), .last_addr_o(last_addr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({5'h00, reg_rdata_o}, {5'h00, e});
  endtask

  // bounded wait: 0 entry, 1 push, 2 counter load, 3 global enable
  task automatic wait_hi(input int sel);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      s = (sel == 0) ? entry : (sel == 1) ? push : (sel == 2) ? load : glob_en;
    end while (s !== 1'b1 && n < 300);
    chk({12'h000, s}, 13'h0001);
  endtask

  task automatic entry_seq();
    wait_hi(0);
    chk({12'h000, glob_en}, 13'h0000);
    chk({12'h000, pend}, 13'h0001);
    rd_chk(`OFS_STATUS, 8'h02);
    wait_hi(1);
    chk(push_data, last_addr);
    wait_hi(2);
    chk(pc, 13'h0004);
    chk({12'h000, entry}, 13'h0000);
  endtask

  task automatic ret_seq();
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    wait_hi(3);
  endtask

  task automatic quiet();
    repeat (24) @(posedge clk_i);
    #1;
    chk({11'h000, pend, entry}, 13'h0000);
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    int lat;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`OFS_CONTROL, 8'h00);
    rd_chk(`OFS_OPTION, 8'h40);
    rd_chk(`OFS_PFLAG_A, 8'h00);
    wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
    wr(`OFS_STATUS, 8'hff);
    rd_chk(`OFS_STATUS, 8'h00);
    $display("test reset finished");
    @(posedge clk_i);
    timer_ovf <= 1'b1;
    ev_a <= 8'hff;
    ev_b <= 3'h7;
    port_pins <= 4'h8;
    @(posedge clk_i);
    timer_ovf <= 1'b0;
    ev_a <= 8'h00;
    ev_b <= 3'h0;
    repeat (8) @(posedge clk_i);
    rd_chk(`OFS_CONTROL, 8'h05);
    rd_chk(`OFS_PFLAG_A, 8'hff);
    rd_chk(`OFS_PFLAG_B, 8'h07);
    wr(`OFS_PEN_A, 8'hff);
    wr(`OFS_PEN_B, 8'h07);
    rd_chk(`OFS_PEN_B, 8'h07);
    wr(`OFS_CONTROL, 8'h7d);
    quiet();
    wr(`OFS_CONTROL, 8'h85);
    quiet();
    rd_chk(`OFS_CONTROL, 8'h85);
    wr(`OFS_CONTROL, 8'hc0);
    entry_seq();
    rd_chk(`OFS_CONTROL, 8'h40);
    $display("test peripheral entry finished");
    wr(`OFS_PFLAG_A, 8'h00);
    wr(`OFS_PFLAG_B, 8'h00);
    ret_seq();
    rd_chk(`OFS_CONTROL, 8'hc0);
    wr(`OFS_CONTROL, 8'ha0);
    @(posedge clk_i);
    timer_ovf <= 1'b1;
    @(posedge clk_i);
    timer_ovf <= 1'b0;
    entry_seq();
    $display("test core entry finished");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_OPTION, i[0] ? 8'h00 : 8'h40);
      slow <= i[1];
      pin <= i[0];
      repeat (10) @(posedge clk_i);
      wr(`OFS_CONTROL, 8'h10);
      rd_chk(`OFS_CONTROL, 8'h10);
      ret_seq();
      repeat (i * 3) @(posedge clk_i);
      pin <= ~i[0];
      #1;
      lat = bnd_cnt;
      entry_seq();
      chk({12'h000, (bnd_cnt - lat) inside {3, 4}}, 13'h0001);
    end
    $display("test pin latency finished");
    test_done();
  end
endmodule

`default_nettype wire
